// ### design/timer8_pkg.sv
// timer8_pkg: register map, control field layout, modes and prescaler masks
// for the 8-bit pwm timer; shared by the design and the bench.
// assumes one aligned 32-bit word per register on an ahb-lite bus.
package timer8_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNTER = 8'h04;
    localparam logic [7:0] OFS_COMPARE = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int BIT_FORCE = 7;
    localparam int BIT_MODE_HI = 6;
    localparam int BIT_MODE_LO = 3;
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_MATCH = 1;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // output action selections
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // prescaler masks for clock_select 1..7 (divide by 1,8,32,64,128,256,1024)
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV32 = 10'h01F;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV128 = 10'h07F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

    // waveform modes, in the order of their two-bit encoding
    typedef enum logic [1:0] {MODE_NORMAL, MODE_PHASE, MODE_CTC, MODE_FAST} mode_t;

    // timer_control as it sits in the low byte
    typedef struct packed {
        logic force_strobe;
        logic mode_hi;
        logic [1:0] action;
        logic mode_lo;
        logic [2:0] clock_select;
    } control_t;

endpackage : timer8_pkg

// ### design/timer8_pwm.sv
// timer8_pwm: 8-bit timer/counter with normal, ctc, fast and phase correct
// pwm modes, an internal prescaler and an ahb-lite register slave.
// assumes a single ahb-lite master; inputs are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - fast pwm: overflow at MAX, then wrap
// - fast pwm 2: match clears, bottom sets; 3: match sets, bottom clears
// - fast pwm bottom compare gives one-tick spike
// - fast pwm compare at MAX: constant level
// - fast pwm select 1 toggles on match
// - pwm buffers compare until TOP; others immediate
// - phase correct counts up then down
// - phase correct TOP fixed at 0xFF
// - phase correct overflow at BOTTOM
// - phase correct 2: up clears, down sets; 3: up sets, down clears
// - pwm clear/set: compare at TOP ignored, TOP action kept
// - force strobe makes immediate match, non-pwm
// - forced match: no flag, no clear, reads zero
// - mode in bits 6 and 3
// - nonzero action overrides pin function
// - non-pwm actions: off, toggle, clear, set
// - clock select stops or divides source
// - ctc clears counter after match
// - counter write blocks next match
module timer8_pwm (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic compare_output_o,
    output logic pin_override_o
);
    import timer8_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    control_t control;
    logic [7:0] counter_value;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic count_up;
    logic match_block;
    logic overflow_flag;
    logic compare_match_flag;
    logic compare_output;
    logic [PRESCALE_W-1:0] prescale;
    logic wr_pend;
    logic [7:0] wr_addr;

    // ----------------------------------------------------------------
    // ahb-lite decode
    // ----------------------------------------------------------------
    wire addr_phase = hsel_i & htrans_i[1] & hready_i;
    wire [7:0] rd_addr = haddr_i[7:0];
    wire in_range = (haddr_i[31:8] == 24'h000000);
    wire wr_control = wr_pend & (wr_addr == OFS_CONTROL);
    wire wr_counter = wr_pend & (wr_addr == OFS_COUNTER);
    wire wr_compare = wr_pend & (wr_addr == OFS_COMPARE);
    wire wr_status = wr_pend & (wr_addr == OFS_STATUS);
    wire control_t wr_ctrl = control_t'(hwdata_i[7:0]);

    // read mux; the force strobe is never stored so it always reads zero
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h00000000;
        if (!in_range) begin
            rd_data = 32'h00000000;
        end else if (rd_addr == OFS_CONTROL) begin
            rd_data = {24'h000000, 1'b0, control.mode_hi, control.action,
                       control.mode_lo, control.clock_select};
        end else if (rd_addr == OFS_COUNTER) begin
            rd_data = {24'h000000, counter_value};
        end else if (rd_addr == OFS_COMPARE) begin
            rd_data = {24'h000000, compare_buffer};
        end else if (rd_addr == OFS_STATUS) begin
            rd_data = {30'h00000000, compare_match_flag, overflow_flag};
        end
    end

    // ----------------------------------------------------------------
    // mode and prescaler decode
    // ----------------------------------------------------------------
    wire mode_t mode = mode_t'({control.mode_hi, control.mode_lo});
    wire is_pwm = (mode == MODE_PHASE) | (mode == MODE_FAST);
    wire [1:0] action = control.action;

    // clock_select 0 yields no tick at all, which stops the counter
    logic [PRESCALE_W-1:0] div_mask;
    always_comb begin
        div_mask = MASK_DIV1;
        case (control.clock_select)
            3'h2: div_mask = MASK_DIV8;
            3'h3: div_mask = MASK_DIV32;
            3'h4: div_mask = MASK_DIV64;
            3'h5: div_mask = MASK_DIV128;
            3'h6: div_mask = MASK_DIV256;
            3'h7: div_mask = MASK_DIV1024;
            default: div_mask = MASK_DIV1;
        endcase
    end
    wire tick = (control.clock_select != 3'h0) &
                ((prescale & div_mask) == div_mask);

    // ----------------------------------------------------------------
    // compare and top events, evaluated on the current count
    // ----------------------------------------------------------------
    wire at_max = (counter_value == COUNT_MAX);
    wire at_bottom = (counter_value == COUNT_BOTTOM);
    wire raw_match = tick & ~match_block & (counter_value == compare_value);
    // with compare at TOP and a pwm polarity chosen the match is dropped
    wire top_skip = is_pwm & action[1] & (compare_value == COUNT_MAX);
    wire wave_match = raw_match & ~top_skip;
    wire at_top = tick & at_max & is_pwm;
    wire force_now = wr_control & wr_ctrl.force_strobe & ~is_pwm;

    // next counter value per mode
    logic [7:0] next_count;
    logic next_up;
    always_comb begin
        next_count = counter_value + 8'h01;
        next_up = count_up;
        case (mode)
            MODE_CTC: begin
                if (raw_match) begin
                    next_count = COUNT_BOTTOM;
                end
            end
            MODE_PHASE: begin
                if (count_up && at_max) begin
                    next_count = COUNT_MAX - 8'h01;
                    next_up = 1'b0;
                end else if (!count_up && at_bottom) begin
                    next_count = COUNT_BOTTOM + 8'h01;
                    next_up = 1'b1;
                end else if (!count_up) begin
                    next_count = counter_value - 8'h01;
                end
            end
            default: next_count = counter_value + 8'h01;
        endcase
    end

    // overflow point: bottom in phase correct, max elsewhere
    wire ovf_event = tick & (mode == MODE_PHASE ? at_bottom : at_max);
    wire match_event = raw_match & ~(mode == MODE_CTC ? 1'b0 : top_skip);

    // next compare output level
    logic next_oc;
    always_comb begin
        next_oc = compare_output;
        case (mode)
            MODE_FAST: begin
                if (at_top && action == ACT_CLEAR) begin
                    next_oc = 1'b1;
                end else if (at_top && action == ACT_SET) begin
                    next_oc = 1'b0;
                end else if (wave_match && action == ACT_TOGGLE) begin
                    next_oc = ~compare_output;
                end else if (wave_match && action == ACT_CLEAR) begin
                    next_oc = 1'b0;
                end else if (wave_match && action == ACT_SET) begin
                    next_oc = 1'b1;
                end
            end
            MODE_PHASE: begin
                if (top_skip && at_top) begin
                    next_oc = (action == ACT_CLEAR);
                end else if (wave_match && action[1]) begin
                    next_oc = (action == ACT_SET) ~^ count_up;
                end
            end
            default: begin
                if (wave_match || force_now) begin
                    case (force_now ? wr_ctrl.action : action)
                        ACT_TOGGLE: next_oc = ~compare_output;
                        ACT_CLEAR: next_oc = 1'b0;
                        ACT_SET: next_oc = 1'b1;
                        default: next_oc = compare_output;
                    endcase
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // bus slave: zero wait states, always okay
    // ----------------------------------------------------------------
    // read data is taken from the address phase; the master never overlaps
    // a read address with a write data phase, so no stale data is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            wr_pend <= addr_phase & hwrite_i & in_range;
            wr_addr <= rd_addr;
            hrdata_o <= (addr_phase && !hwrite_i) ? rd_data : 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // control register and pin override
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control <= control_t'(CONTROL_RESET);
            pin_override_o <= 1'b0;
        end else if (wr_control) begin
            control <= control_t'({1'b0, hwdata_i[6:0]});
            pin_override_o <= (wr_ctrl.action != ACT_OFF);
        end
    end

    // ----------------------------------------------------------------
    // counter, compare buffering and prescaler
    // ----------------------------------------------------------------
    // a software write wins over counting in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prescale <= '0;
            counter_value <= COUNT_BOTTOM;
            count_up <= 1'b1;
            match_block <= 1'b0;
        end else begin
            prescale <= (control.clock_select == 3'h0) ? '0 : prescale + 1'b1;
            if (wr_counter) begin
                counter_value <= hwdata_i[7:0];
                match_block <= 1'b1;
            end else if (tick) begin
                counter_value <= next_count;
                count_up <= (mode == MODE_PHASE) ? next_up : 1'b1;
                match_block <= 1'b0;
            end
        end
    end

    // pwm modes take the new compare only at TOP to avoid glitching pulses
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            compare_buffer <= 8'h00;
            compare_value <= 8'h00;
        end else begin
            if (wr_compare) begin
                compare_buffer <= hwdata_i[7:0];
            end
            if (!is_pwm && wr_compare) begin
                compare_value <= hwdata_i[7:0];
            end else if (!is_pwm) begin
                compare_value <= compare_buffer;
            end else if (at_top) begin
                compare_value <= compare_buffer;
            end
        end
    end

    // ----------------------------------------------------------------
    // flags and output; a set in the clearing cycle wins
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_flag <= 1'b0;
            compare_match_flag <= 1'b0;
            compare_output <= 1'b0;
            compare_output_o <= 1'b0;
        end else begin
            overflow_flag <= ovf_event |
                (overflow_flag & ~(wr_status & hwdata_i[BIT_OVERFLOW]));
            // forced matches never reach this flag
            compare_match_flag <= match_event |
                (compare_match_flag & ~(wr_status & hwdata_i[BIT_MATCH]));
            compare_output <= next_oc;
            compare_output_o <= next_oc;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_fast_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_FAST && tick && at_max && !wr_counter)
        |=> (counter_value == COUNT_BOTTOM) && overflow_flag)
        else $error("fast pwm overflow missed");

    a_fast_bottom_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_FAST && at_top && action == ACT_CLEAR) |=> compare_output_o)
        else $error("fast pwm output not set at bottom");

    a_fast_match_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_FAST && wave_match && !at_max && action == ACT_CLEAR)
        |=> !compare_output_o)
        else $error("fast pwm output not cleared on match");

    a_fast_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_FAST && wave_match && action == ACT_TOGGLE)
        |=> compare_output_o != $past(compare_output_o))
        else $error("fast pwm toggle missed");

    a_phase_reverse: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_PHASE && tick && count_up && at_max && !wr_counter)
        |=> !count_up && counter_value == 8'hFE)
        else $error("phase correct did not reverse at max");

    a_phase_up_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_PHASE && wave_match && count_up && action == ACT_CLEAR)
        |=> !compare_output_o)
        else $error("phase correct up match did not clear");

    a_ctc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode == MODE_CTC && raw_match && !wr_counter) |=> counter_value == COUNT_BOTTOM)
        else $error("ctc did not clear counter");

    a_write_blocks: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_counter |=> !raw_match)
        else $error("match after counter write");

    a_force_set: assert property (@(posedge clk_i) disable iff (rst_i)
        (force_now && wr_ctrl.action == ACT_SET) |=> compare_output_o && (!compare_match_flag
        || $past(compare_match_flag) || $past(match_event)))
        else $error("forced set missed or flagged");

    a_stopped: assert property (@(posedge clk_i) disable iff (rst_i)
        (control.clock_select == 3'h0 && !wr_counter) |=> $stable(counter_value))
        else $error("counter moved while stopped");

endmodule : timer8_pwm
`default_nettype wire

// ### verification/pin_load_model.sv
// pin_load_model: the port pin that compare_output drives, with its
// direction bit, the port's own data and a pull-up on the pad.
// assumes all inputs are levels synchronous to the timer clock.
`timescale 1ns/1ps
`default_nettype none

module pin_load_model (
    input wire logic compare_output_i,
    input wire logic override_i,
    input wire logic dir_out_i,
    input wire logic port_data_i,
    output logic pin_o
);
    // ----------------------------------------------------------------
    // pad level
    // ----------------------------------------------------------------
    // override only picks the source; the driver still needs dir_out
    wire logic src = override_i ? compare_output_i : port_data_i;
    // an undriven pad floats up to the pull-up, never the last value
    assign pin_o = dir_out_i ? src : 1'b1;
endmodule : pin_load_model

`default_nettype wire

// ### verification/tb.sv
// tb: self-checking bench for timer8_pwm over ahb-lite, with a pin model.
// assumes zero-wait-state slave and a tick every clock for clock_select 1.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import timer8_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
    logic hreadyout_o, hresp_o, compare_output_o, pin_override_o, pin;
    logic dir_out = 1'b1, port_data = 1'b0;
    int num_errors = 0, tests_run = 0;

    timer8_pwm timer8_pwm_inst (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .compare_output_o(compare_output_o), .pin_override_o(pin_override_o));
    pin_load_model pin_load_model_inst (.compare_output_i(compare_output_o),
        .override_i(pin_override_o), .dir_out_i(dir_out), .port_data_i(port_data),
        .pin_o(pin));

    // ----------------------------------------------------------------
    // clock, verdict and watchdog
    // ----------------------------------------------------------------
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic conclude();
        $display("checks %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    // the whole run is about 19k cycles; allow about three times that
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        $display("[ERR] %0t timeout", $time);
        conclude();
    end

    // ----------------------------------------------------------------
    // bus and compare helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %0h want %0h", $time, m, got, exp);
        end
    endtask : chk
    // address phase held until hready, then data phase until hready again
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= wr;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (hreadyout_o !== 1'b1) @(posedge clk_i);
        q = hrdata_o;
        chk({31'h0, hresp_o}, 32'h0, "response not okay");
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, m);
    endtask : rd_chk
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] a,
                                        input logic [2:0] cs, input logic f);
        return {24'h0, f, m[1], a, m[0], cs};
    endfunction : ctl

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd_chk(OFS_CONTROL, 32'h0, "control after reset");
        chk({31'h0, compare_output_o}, 32'h0, "output after reset");
        chk({31'h0, pin_override_o}, 32'h0, "override after reset");
        rd_chk(8'h10, 32'h0, "unmapped read");
        $display("test reset done");
    endtask : t_reset
    // forced matches with the timer stopped: set, clear, toggle
    task automatic t_force();
        wr(OFS_CONTROL, ctl(2'h0, ACT_SET, 3'h0, 1'b1));
        @(posedge clk_i);
        chk({31'h0, compare_output_o}, 32'h1, "forced set");
        chk({31'h0, pin}, 32'h1, "pin follows output");
        rd_chk(OFS_CONTROL, ctl(2'h0, ACT_SET, 3'h0, 1'b0), "strobe reads zero");
        wr(OFS_CONTROL, ctl(2'h2, ACT_CLEAR, 3'h0, 1'b1));
        @(posedge clk_i);
        chk({31'h0, compare_output_o}, 32'h0, "forced clear");
        chk({31'h0, pin}, 32'h0, "pin follows clear");
        // direction bit off: the pad must float up even though the output is low
        dir_out <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, pin}, 32'h1, "released pad pulls up");
        dir_out <= 1'b1;
        wr(OFS_CONTROL, ctl(2'h0, ACT_TOGGLE, 3'h0, 1'b1));
        @(posedge clk_i);
        chk({31'h0, compare_output_o}, 32'h1, "forced toggle");
        rd_chk(OFS_STATUS, 32'h0, "no flag on forced match");
        wr(OFS_CONTROL, ctl(2'h0, ACT_OFF, 3'h0, 1'b0));
        @(posedge clk_i);
        chk({31'h0, pin_override_o}, 32'h0, "override released");
        $display("test force done");
    endtask : t_force
    // high cycles over a whole number of periods, which is phase independent
    task automatic t_duty(input logic [1:0] m, input logic [1:0] a, input logic [7:0] c,
                          input int win, input int exp, input string n);
        int hi;
        hi = 0;
        wr(OFS_CONTROL, ctl(2'h0, ACT_OFF, 3'h0, 1'b0));
        wr(OFS_COMPARE, {24'h0, c});
        wr(OFS_COUNTER, 32'h0);
        wr(OFS_CONTROL, ctl(m, a, 3'h1, 1'b0));
        repeat (1100) @(posedge clk_i);
        for (int i = 0; i < win; i++) begin
            @(posedge clk_i);
            hi += (compare_output_o === 1'b1) ? 1 : 0;
        end
        chk(hi, exp, n);
        $display("test duty %s done", n);
    endtask : t_duty
    task automatic t_flag();
        wr(OFS_CONTROL, ctl(2'h3, ACT_OFF, 3'h0, 1'b0));
        wr(OFS_COUNTER, 32'hFE);
        wr(OFS_STATUS, 32'h3);
        rd_chk(OFS_STATUS, 32'h0, "flags cleared");
        wr(OFS_CONTROL, ctl(2'h3, ACT_OFF, 3'h1, 1'b0));
        // the flag rises on the edge that ends the MAX cycle, after the read
        // address would be sampled; wait past it, well before the compare match
        repeat (2) @(posedge clk_i);
        rd_chk(OFS_STATUS, 32'h1, "overflow at max");
        $display("test flag done");
    endtask : t_flag
    // divided clocks: 1024 cycles give 1024/N ticks, one tick of bus slack
    task automatic t_prescale();
        int div [2:7] = '{8, 32, 64, 128, 256, 1024};
        logic [31:0] q;
        for (int cs = 2; cs <= 7; cs++) begin
            wr(OFS_CONTROL, 32'h0);
            wr(OFS_COUNTER, 32'h0);
            wr(OFS_CONTROL, ctl(2'h0, ACT_OFF, cs[2:0], 1'b0));
            repeat (1024) @(posedge clk_i);
            bus(1'b0, OFS_COUNTER, 32'h0, q);
            tests_run++;
            if ($isunknown(q) || q > 1024 / div[cs] + 1 || q + 1 < 1024 / div[cs]) begin
                num_errors++;
                $display("[ERR] %0t prescale %0d count %0d", $time, cs, q);
            end
        end
        wr(OFS_CONTROL, 32'h0);
        bus(1'b0, OFS_COUNTER, 32'h0, q);
        repeat (50) @(posedge clk_i);
        rd_chk(OFS_COUNTER, q, "stopped timer holds");
        $display("test prescale done");
    endtask : t_prescale

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_force();
        t_duty(2'h3, ACT_CLEAR, 8'h80, 256, 129, "fast clear");
        t_duty(2'h3, ACT_SET, 8'h80, 256, 127, "fast set");
        t_duty(2'h3, ACT_CLEAR, 8'h00, 256, 1, "fast spike");
        t_duty(2'h3, ACT_CLEAR, 8'hFF, 256, 256, "fast max high");
        t_duty(2'h3, ACT_SET, 8'hFF, 256, 0, "fast max low");
        t_duty(2'h3, ACT_TOGGLE, 8'h00, 512, 256, "fast toggle");
        t_duty(2'h1, ACT_CLEAR, 8'h80, 510, 256, "phase clear");
        t_duty(2'h1, ACT_SET, 8'h80, 510, 254, "phase set");
        t_duty(2'h2, ACT_TOGGLE, 8'h09, 200, 100, "ctc toggle");
        t_flag();
        t_prescale();
        conclude();
    end
endmodule : tb

`default_nettype wire
